// *** design/ormr_pkg.sv ***
`default_nettype none
package ormr_pkg;
	localparam int unsigned ORMR_INSN_W    = 14;
	localparam int unsigned ORMR_DATA_W    = 8;
	localparam int unsigned ORMR_ADDR_W    = 7;
	localparam int unsigned ORMR_PC_W      = 13;
	// instruction field positions
	localparam int unsigned ORMR_DEST_BIT  = 7;
	localparam int unsigned ORMR_ADDR_MSB  = 6;
	localparam int unsigned ORMR_LIT_MSB   = 7;
	localparam int unsigned ORMR_OPC_MSB   = 13;
	localparam int unsigned ORMR_OPC_LSB   = 8;
	// opcode fields: six bits, four bits for load literal, the full word for interrupt return
	localparam logic [5:0] ORMR_OPC_OR_REG   = 6'h04;
	localparam logic [5:0] ORMR_OPC_MOVE_REG = 6'h08;
	localparam logic [5:0] ORMR_OPC_ROT_LEFT = 6'h0d;
	localparam logic [5:0] ORMR_OPC_OR_LIT   = 6'h38;
	localparam logic [5:0] ORMR_OPC_MISC     = 6'h00;
	localparam logic [3:0] ORMR_OPC_LIT_LOAD = 4'hc;
	localparam logic [13:0] ORMR_INSN_RET_INT = 14'h0009;
	// global interrupt enable position in the interrupt control register
	localparam int unsigned ORMR_GIE_BIT   = 7;
	// reset values
	localparam logic [7:0]  ORMR_ACC_RST   = 8'h00;
	localparam logic [12:0] ORMR_PC_RST    = 13'h0000;
	localparam logic        ORMR_FLAG_RST  = 1'b0;
	typedef enum logic [3:0] {
		ORMR_OP_NONE,
		ORMR_OP_OR_LIT,
		ORMR_OP_OR_REG,
		ORMR_OP_MOVE_REG,
		ORMR_OP_LIT_LOAD,
		ORMR_OP_ACC_STORE,
		ORMR_OP_NOP,
		ORMR_OP_RET_INT,
		ORMR_OP_ROT_LEFT
	} ormr_op_e;
endpackage
`default_nettype wire

// *** design/ormr_decode.sv ***
`default_nettype none
module ormr_decode
(
	input  wire logic [ormr_pkg::ORMR_INSN_W-1:0] insn,
	output ormr_pkg::ormr_op_e                   op
);
	import ormr_pkg::*;

	logic [5:0] opc;

	always_comb
	begin
		opc = insn[ORMR_OPC_MSB:ORMR_OPC_LSB];
		op  = ORMR_OP_NONE;
		if (opc == ORMR_OPC_OR_LIT)
			op = ORMR_OP_OR_LIT;
		else if (opc == ORMR_OPC_OR_REG)
			op = ORMR_OP_OR_REG;
		else if (opc == ORMR_OPC_MOVE_REG)
			op = ORMR_OP_MOVE_REG;
		else if (opc[5:2] == ORMR_OPC_LIT_LOAD)
			op = ORMR_OP_LIT_LOAD;
		else if (opc == ORMR_OPC_ROT_LEFT)
			op = ORMR_OP_ROT_LEFT;
		else if (insn == ORMR_INSN_RET_INT)
			op = ORMR_OP_RET_INT;
		else if (opc == ORMR_OPC_MISC && insn[ORMR_DEST_BIT])
			op = ORMR_OP_ACC_STORE;
		else if (opc == ORMR_OPC_MISC && insn[7] == 1'b0 && insn[4:0] == 5'h00)
			op = ORMR_OP_NOP;
	end
endmodule // ormr_decode
`default_nettype wire

// *** design/ormr_core.sv ***
`default_nettype none
// Summary of operation
// - or literal into accumulator, zero only
// - or register, destination bit selects target
// - move register to accumulator or itself
// - move updates zero even writing back
// - load literal, flags untouched
// - interrupt return pops stack into pc
// - interrupt return sets global enable
// - interrupt return takes two cycles
// - rotate left through carry, carry only
module ormr_core
(
	input  wire logic                                mclk,
	input  wire logic                                rst_b,
	input  wire logic                                clk_en,
	input  wire logic                                insn_valid,
	input  wire logic [ormr_pkg::ORMR_INSN_W-1:0]    insn,
	output logic                                     insn_ready,
	output logic [ormr_pkg::ORMR_ADDR_W-1:0]         file_addr,
	input  wire logic [ormr_pkg::ORMR_DATA_W-1:0]    file_rdata,
	output logic                                     file_we,
	output logic [ormr_pkg::ORMR_DATA_W-1:0]         file_wdata,
	output logic                                     stack_pop,
	input  wire logic [ormr_pkg::ORMR_PC_W-1:0]      stack_top_entry,
	output logic                                     global_irq_enable_set,
	input  wire logic [ormr_pkg::ORMR_DATA_W-1:0]    interrupt_control_reg,
	output logic [ormr_pkg::ORMR_DATA_W-1:0]         interrupt_control_wdata,
	output logic [ormr_pkg::ORMR_DATA_W-1:0]         acc_q,
	output logic                                     zero_flag_q,
	output logic                                     carry_flag_q,
	output logic [ormr_pkg::ORMR_PC_W-1:0]           pc_q,
	output logic                                     unknown_op
);
	import ormr_pkg::*;

	typedef enum logic {ORMR_ST_EXEC, ORMR_ST_FLUSH} ormr_state_e;

	ormr_op_e                 op;
	ormr_state_e              state_q, state_d;
	logic [ORMR_DATA_W-1:0]   acc_d;
	logic                     zero_flag_d;
	logic                     carry_flag_d;
	logic [ORMR_PC_W-1:0]     pc_d;
	logic [ORMR_DATA_W-1:0]   result;
	logic                     dest_file;
	logic                     fire;

	function automatic logic is_zero(input logic [ORMR_DATA_W-1:0] v);
		return v == '0;
	endfunction

	// literal field, shared by the or and load paths
	function automatic logic [ORMR_DATA_W-1:0] lit_of(input logic [ORMR_INSN_W-1:0] w);
		return w[ORMR_LIT_MSB:0];
	endfunction

	// pc wraps silently at the top of program space
	function automatic logic [ORMR_PC_W-1:0] pc_step(input logic [ORMR_PC_W-1:0] p);
		return p + 13'h0001;
	endfunction

	ormr_decode u_decode
	(
		.insn (insn),
		.op   (op)
	);

	assign dest_file = insn[ORMR_DEST_BIT];
	// address follows insn even when idle; reads are harmless
	assign file_addr = insn[ORMR_ADDR_MSB:0];

	// second cycle of a return refuses new instructions
	assign insn_ready = (state_q == ORMR_ST_EXEC);
	assign fire       = clk_en && insn_valid && insn_ready;
	// unknown codes run as nop so a stray word never wedges the core
	assign unknown_op = insn_valid && (op == ORMR_OP_NONE);
	assign interrupt_control_wdata = interrupt_control_reg | (8'h01 << ORMR_GIE_BIT);

	always_comb
	begin
		state_d = state_q;
		if (state_q == ORMR_ST_FLUSH)
		begin
			state_d = ORMR_ST_EXEC;
		end
		else if (fire && op == ORMR_OP_RET_INT)
		begin
			state_d = ORMR_ST_FLUSH;
		end
	end

	// only enabled edges move the return state
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= ORMR_ST_EXEC;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
		end
	end

	always_comb
	begin
		acc_d        = acc_q;
		zero_flag_d  = zero_flag_q;
		carry_flag_d = carry_flag_q;
		pc_d         = pc_q;
		result       = file_rdata;
		file_we      = 1'b0;
		file_wdata   = file_rdata;
		stack_pop    = 1'b0;
		global_irq_enable_set = 1'b0;
		// fire is low in the dead return cycle, so nothing moves there
		if (fire)
		begin
			pc_d = pc_step(pc_q);
			case (op)
				ORMR_OP_OR_LIT:
				begin
					result      = acc_q | lit_of(insn);
					acc_d       = result;
					zero_flag_d = is_zero(result);
				end
				ORMR_OP_OR_REG:
				begin
					result      = acc_q | file_rdata;
					zero_flag_d = is_zero(result);
					if (dest_file)
					begin
						file_we = 1'b1;
					end
					else
					begin
						acc_d = result;
					end
					file_wdata = result;
				end
				ORMR_OP_MOVE_REG:
				begin
					result = file_rdata;
					zero_flag_d = is_zero(result);
					if (dest_file)
					begin
						file_we = 1'b1;
					end
					else
					begin
						acc_d = result;
					end
				end
				ORMR_OP_LIT_LOAD:
				begin
					acc_d = lit_of(insn);
				end
				ORMR_OP_ACC_STORE:
				begin
					file_we    = 1'b1;
					file_wdata = acc_q;
				end
				ORMR_OP_RET_INT:
				begin
					stack_pop = 1'b1;
					pc_d      = stack_top_entry;
					global_irq_enable_set = 1'b1;
				end
				ORMR_OP_ROT_LEFT:
				begin
					result       = {file_rdata[6:0], carry_flag_q};
					carry_flag_d = file_rdata[7];
					if (dest_file)
					begin
						file_we = 1'b1;
					end
					else
					begin
						acc_d = result;
					end
					file_wdata = result;
				end
				default:
				begin
					// nop and unknown codes only advance pc
					pc_d = pc_step(pc_q);
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_q        <= ORMR_ACC_RST;
			zero_flag_q  <= ORMR_FLAG_RST;
			carry_flag_q <= ORMR_FLAG_RST;
			pc_q         <= ORMR_PC_RST;
		end
		else if (clk_en)
		begin
			acc_q        <= acc_d;
			zero_flag_q  <= zero_flag_d;
			carry_flag_q <= carry_flag_d;
			// everything holds while clk_en is low
			pc_q         <= pc_d;
		end
	end
endmodule // ormr_core
`default_nettype wire

// *** dv/ormr_props.sv ***
`default_nettype none
module ormr_props
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        clk_en,
	input wire logic        insn_valid,
	input wire logic [13:0] insn,
	input wire logic        insn_ready,
	input wire logic [7:0]  file_rdata,
	input wire logic        file_we,
	input wire logic [7:0]  file_wdata,
	input wire logic        stack_pop,
	input wire logic [12:0] stack_top_entry,
	input wire logic [7:0]  acc_q,
	input wire logic        zero_flag_q,
	input wire logic        carry_flag_q,
	input wire logic [12:0] pc_q
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic       f  = clk_en & insn_valid & insn_ready;
	wire logic [5:0] op = insn[13:8];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence ret_s;
		f && insn == 14'h0009;
	endsequence
	or_lit_a: assert property (f && op == 6'h38 |=> acc_q == ($past(acc_q) | $past(insn[7:0]))
		&& zero_flag_q == (acc_q == 8'h00) && $stable(carry_flag_q)) else $error("or literal wrong");
	or_reg_a: assert property (f && op == 6'h04 && insn[7] |-> file_we
		&& file_wdata == (acc_q | file_rdata)) else $error("or register write wrong");
	move_zero_a: assert property (f && op == 6'h08 && insn[7] |-> file_we && file_wdata == file_rdata
		##1 zero_flag_q == ($past(file_rdata) == 8'h00)) else $error("move zero wrong");
	lit_load_a: assert property (f && insn[13:10] == 4'hc |=> acc_q == $past(insn[7:0])
		&& $stable(zero_flag_q) && $stable(carry_flag_q)) else $error("load literal wrong");
	ret_pop_a: assert property (ret_s |-> stack_pop ##1 pc_q == $past(stack_top_entry) && !insn_ready)
		else $error("interrupt return wrong");
	rot_carry_a: assert property (f && op == 6'h0d |=> carry_flag_q == $past(file_rdata[7])
		&& $stable(zero_flag_q)) else $error("rotate carry wrong");
	rot_write_a: assert property (f && op == 6'h0d && insn[7] |-> file_we
		&& file_wdata == {file_rdata[6:0], carry_flag_q}) else $error("rotate write wrong");
	acc_store_a: assert property (f && insn[13:7] == 7'h01 |-> file_we && file_wdata == acc_q)
		else $error("store wrong");
endmodule // ormr_props
bind ormr_core ormr_props chk_u (.*);
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk = 0, rst_b = 0, clk_en = 1, insn_valid = 0;
	logic [13:0] insn = 0;
	logic [12:0] stack_top_entry = 0, pc_q;
	logic [7:0]  interrupt_control_reg = 0, interrupt_control_wdata, acc_q, file_rdata, file_wdata;
	logic [6:0]  file_addr;
	logic        insn_ready, file_we, stack_pop, global_irq_enable_set, zero_flag_q, carry_flag_q, unknown_op;
	logic [7:0]  mem [128];
	int          fails = 0, cmp_count = 0;
	// async file read, like the real register file
	assign file_rdata = mem[file_addr];
	always @(posedge mclk) if (file_we) mem[file_addr] <= file_wdata;
	ormr_core dut_u (.*);
	initial forever #5 mclk = ~mclk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// idle cycle between ops keeps one driver update per edge
	task ex(input logic [13:0] w);
		@(posedge mclk);
		insn <= w;
		insn_valid <= 1;
		@(posedge mclk);
		insn_valid <= 0;
		#1;
	endtask
	task t_lit_or;
		ex(14'h3300); chk(zero_flag_q, 0);
		ex(14'h3800); chk(zero_flag_q, 1);
		ex(14'h33a5); chk(acc_q, 8'ha5); chk(zero_flag_q, 1);
		ex(14'h3842); chk(acc_q, 8'he7); chk(zero_flag_q, 0);
	endtask
	task t_or_reg;
		ex(14'h3030); ex(14'h0485); chk(mem[5], 8'h3f); chk(acc_q, 8'h30);
		ex(14'h0405); chk(acc_q, 8'h3f);
	endtask
	task t_move;
		ex(14'h0886); chk(zero_flag_q, 1); chk(acc_q, 8'h3f);
		ex(14'h0807); chk(acc_q, 8'h81); chk(zero_flag_q, 0);
	endtask
	task t_rot;
		ex(14'h0d87); chk(mem[7], 8'h02); chk(carry_flag_q, 1);
		ex(14'h0d07); chk(acc_q, 8'h05); chk(carry_flag_q, 0);
	endtask
	task t_ret;
		@(posedge mclk);
		stack_top_entry <= 13'h1abc;
		interrupt_control_reg <= 8'h05;
		insn <= 14'h0009;
		insn_valid <= 1;
		#1;
		chk(stack_pop, 1); chk(global_irq_enable_set, 1); chk(interrupt_control_wdata, 8'h85);
		@(posedge mclk);
		insn_valid <= 0;
		#1;
		chk(pc_q, 13'h1abc); chk(insn_ready, 0); chk(zero_flag_q, 0);
	endtask
	task t_store_nop;
		ex(14'h0089); chk(mem[9], 8'h05);
		ex(14'h0060); chk(pc_q, 13'h1abe); chk(acc_q, 8'h05);
		@(posedge mclk);
		insn <= 14'h0001;
		insn_valid <= 1;
		#1;
		chk(unknown_op, 1);
		@(posedge mclk);
		insn_valid <= 0;
		#1;
		chk(pc_q, 13'h1abf); chk(acc_q, 8'h05);
	endtask
	task t_freeze;
		@(posedge mclk);
		insn <= 14'h3077;
		insn_valid <= 1;
		clk_en <= 0;
		@(posedge mclk);
		clk_en <= 1;
		#1;
		chk(acc_q, 8'h05); chk(pc_q, 13'h1abf); chk(unknown_op, 0);
		@(posedge mclk);
		insn_valid <= 0;
		#1;
		chk(acc_q, 8'h77); chk(pc_q, 13'h1ac0);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[5] = 8'h0f;
		mem[7] = 8'h81;
		repeat (3) @(posedge mclk);
		rst_b <= 1;
		t_lit_or;
		t_or_reg;
		t_move;
		t_rot;
		t_ret;
		t_store_nop;
		t_freeze;
		final_report;
	end
	// about 36 cycles expected
	initial
	begin
		#3000;
		fails++;
		final_report;
	end
endmodule // tb_top
`default_nettype wire
